// >>> rtl/swc_top.sv
/*
 * Supervisor and watchdog configuration block: APB register file for the
 * two configuration words, capture of the words at each device reset,
 * power-up delay, reset-pin handling and the decoded settings outputs.
 * Assumes a single 10 MHz clock, an APB master on it, an asynchronous
 * pin for the shared reset line and a sleep level from on-chip logic.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// RL1: brown-out mode 11 keeps reset always active
// RL2: mode 10 arms brown-out only while awake
// RL3: mode 01 follows software bit, 00 off
// RL4: active brown-out takes threshold from level bit
// RL5: low-power brown-out bit is active low
// RL6: delay field 11 none, 10/01/00 64/16/1 ms
// RL7: low-voltage programming forces pin to reset function
// RL8: otherwise pin enable picks reset or port
// RL9: programmer keeps debugger bit at one
// RL10: source field picks watchdog clock or software
// RL11: window codes 111/110 fully open, software changeable
// RL12: lower codes fix closed part, keyed, locked
// RL13: watchdog mode 11 runs always, sleep too
// RL14: mode 10 runs awake, suspended in sleep
// RL15: mode 01 follows software bit, 00 off
// RL16: period field loads period at power-on
// RL17: period code 11111 loads 01011, software changeable
// RL18: level bit one picks lower trip point
// RL19: settings captured at reset, held until next
module swc_top #(
    parameter int unsigned DLY_1MS_CYC = swc_pkg::POWERUP_DELAY_TIMER_1MS_CYC,
    parameter int unsigned DLY_16MS_CYC = swc_pkg::POWERUP_DELAY_TIMER_16MS_CYC,
    parameter int unsigned DLY_64MS_CYC = swc_pkg::POWERUP_DELAY_TIMER_64MS_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_active,
    input wire logic external_reset_pin,
    output logic device_reset_hold,
    output logic port_e_bit_three_sel,
    output swc_pkg::swc_cfg_s cfg_out
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [13:0] sup_word;
    logic [13:0] wdg_word;
    logic [13:0] sup_cap;
    logic [13:0] wdg_cap;
    logic lvp_cap;
    logic [5:0] ctrl;
    logic [4:0] per_run;
    logic [2:0] win_run;
    logic pin_s1;
    logic pin_s2;
    logic [19:0] dly_cnt;
    logic [19:0] next_dly_cnt;
    swc_pkg::swc_state_e state;
    swc_pkg::swc_state_e next_state;
    swc_pkg::swc_cfg_s dec;
    swc_pkg::swc_cfg_s cfg_q;
    logic hold_q;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire logic setup = psel & ~penable;
    wire logic access = psel & penable;
    wire logic wr = access & pwrite;
    wire logic aligned = (paddr[1:0] == 2'h0);
    wire logic [15:0] idx = paddr[17:2];
    wire logic hit_sup = aligned & (idx == swc_pkg::IDX_SUP);
    wire logic hit_wdg = aligned & (idx == swc_pkg::IDX_WDG);
    wire logic hit_ctrl = aligned & (idx == swc_pkg::IDX_CTRL);
    wire logic hit_run = aligned & (idx == swc_pkg::IDX_RUN);
    wire logic hit_stat = aligned & (idx == swc_pkg::IDX_STAT);
    wire logic mapped = hit_sup | hit_wdg | hit_ctrl | hit_run | hit_stat;

    // zero wait states, error only for unmapped addresses
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // read mux, sampled in the setup phase
    wire logic [31:0] rd_mux = hit_sup ? {18'h0, sup_word}
        : hit_wdg ? {18'h0, wdg_word}
        : hit_ctrl ? {26'h0, ctrl}
        : hit_run ? {21'h0, win_run, 3'h0, per_run}
        : hit_stat ? {10'h0, hold_q, pin_s2, cfg_q}
        : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup & ~pwrite) begin
            prdata <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // configuration words and software control
    // ----------------------------------------------------------------
    // programmed words, act only after the next capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_word <= swc_pkg::CFG_RESET;
            wdg_word <= swc_pkg::CFG_RESET;
        end else begin
            if (wr & hit_sup) sup_word <= pwdata[13:0];
            if (wr & hit_wdg) wdg_word <= pwdata[13:0];
        end
    end

    // resample bit is a strobe and reads as zero
    wire logic resample = wr & hit_ctrl & pwdata[swc_pkg::CTRL_RESAMPLE];
    wire logic [5:0] ctrl_wr = pwdata[5:0] & ~(6'h01 << swc_pkg::CTRL_RESAMPLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= swc_pkg::CTRL_RESET;
        end else if (wr & hit_ctrl) begin
            ctrl <= ctrl_wr;
        end
    end

    // ----------------------------------------------------------------
    // reset pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
        end else begin
            pin_s1 <= external_reset_pin;
            pin_s2 <= pin_s1;
        end
    end

    wire logic pin_reset = cfg_q.pin_is_reset & ~pin_s2; // see RL7 see RL8

    // ----------------------------------------------------------------
    // capture, power-up delay and run sequence
    // ----------------------------------------------------------------
    wire logic [1:0] powerup_delay_select = sup_word[swc_pkg::SUP_POWERUP_DELAY_SELECT_LO +: 2];
    wire logic [4:0] cps = wdg_word[swc_pkg::WDG_CPS_LO +: 5];
    wire logic [4:0] per_load = (cps == swc_pkg::CPS_SW) ? swc_pkg::CPS_SW_LOAD : cps; // see RL16 see RL17
    wire logic [19:0] dly_target = (powerup_delay_select == 2'h3) ? 20'h0 // see RL6
        : (powerup_delay_select == 2'h2) ? 20'(DLY_64MS_CYC)
        : (powerup_delay_select == 2'h1) ? 20'(DLY_16MS_CYC)
        : 20'(DLY_1MS_CYC);
    wire logic restart = pin_reset | resample;

    always_comb begin
        next_state = state;
        next_dly_cnt = dly_cnt;
        unique case (state)
            swc_pkg::ST_CAPTURE: begin
                next_state = swc_pkg::ST_DELAY;
                next_dly_cnt = dly_target;
            end
            swc_pkg::ST_DELAY: begin
                if (restart) begin
                    next_state = swc_pkg::ST_CAPTURE;
                end else if (dly_cnt == 20'h0) begin
                    next_state = swc_pkg::ST_RUN;
                end else begin
                    next_dly_cnt = dly_cnt - 20'h1;
                end
            end
            swc_pkg::ST_RUN: begin
                if (restart) next_state = swc_pkg::ST_CAPTURE; // see RL8
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= swc_pkg::ST_CAPTURE;
            dly_cnt <= 20'h0;
            hold_q <= 1'b1;
        end else begin
            state <= next_state;
            dly_cnt <= next_dly_cnt;
            hold_q <= (next_state != swc_pkg::ST_RUN);
        end
    end

    // snapshot of the words, held until the next capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_cap <= swc_pkg::CFG_RESET;
            wdg_cap <= swc_pkg::CFG_RESET;
            lvp_cap <= 1'b1;
        end else if (state == swc_pkg::ST_CAPTURE) begin
            sup_cap <= sup_word; // see RL19
            wdg_cap <= wdg_word;
            lvp_cap <= ctrl[swc_pkg::CTRL_LVP];
        end
    end

    // ----------------------------------------------------------------
    // runtime period and window
    // ----------------------------------------------------------------
    wire logic run_wr = wr & hit_run & (state == swc_pkg::ST_RUN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_run <= swc_pkg::CPS_SW_LOAD;
            win_run <= swc_pkg::CWS_CLOSED_BASE;
        end else if (state == swc_pkg::ST_CAPTURE) begin
            per_run <= per_load; // see RL16 see RL17
            win_run <= wdg_word[swc_pkg::WDG_CWS_LO +: 3];
        end else if (run_wr) begin
            if (cfg_q.period_sw_ok) per_run <= pwdata[swc_pkg::RUN_PER_LO +: 5]; // see RL17
            if (cfg_q.win_sw_ok) win_run <= pwdata[swc_pkg::RUN_WIN_LO +: 3]; // see RL11 see RL12
        end
    end

    // ----------------------------------------------------------------
    // decode and registered outputs
    // ----------------------------------------------------------------
    swc_decode u_decode (
        .sup_word(sup_cap),
        .wdg_word(wdg_cap),
        .period(per_run),
        .window(win_run),
        .lvp_on(lvp_cap),
        .sleep_active(sleep_active),
        .sw_bor_on(ctrl[swc_pkg::CTRL_SBOR]),
        .sw_wdog_on(ctrl[swc_pkg::CTRL_SWDT]),
        .sw_clk_sel(ctrl[swc_pkg::CTRL_CLK_LO +: 2]),
        .cfg(dec)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= dec;
        end
    end

    assign cfg_out = cfg_q;
    assign device_reset_hold = hold_q;
    assign port_e_bit_three_sel = ~cfg_q.pin_is_reset; // see RL8

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire logic [1:0] bor_m = sup_cap[swc_pkg::SUP_BROWNOUT_MODE_FIELD_LO +: 2];
    wire logic [1:0] wdg_m = wdg_cap[swc_pkg::WDG_MODE_LO +: 2];

    sequence s_capture;
        state == swc_pkg::ST_CAPTURE;
    endsequence

    sequence s_settled;
        state == swc_pkg::ST_RUN [*2];
    endsequence

    property p_bor_always;
        presetn && (bor_m == swc_pkg::MODE_ON) |=> cfg_q.bor_active;
    endproperty
    a_bor_always: assert property (p_bor_always) else $error("brown-out not forced on"); // see RL1

    property p_bor_sleep;
        (bor_m == swc_pkg::MODE_AWAKE) && sleep_active |=> !cfg_q.bor_active;
    endproperty
    a_bor_sleep: assert property (p_bor_sleep) else $error("brown-out armed in sleep"); // see RL2

    property p_bor_sw;
        bor_m == swc_pkg::MODE_SW |=> cfg_q.bor_active == $past(ctrl[swc_pkg::CTRL_SBOR]);
    endproperty
    a_bor_sw: assert property (p_bor_sw) else $error("brown-out ignores software bit"); // see RL3

    property p_trip;
        cfg_q.bor_active |-> cfg_q.bor_low_trip == $past(sup_cap[swc_pkg::SUP_BROWNOUT_LEVEL_SELECT]);
    endproperty
    a_trip: assert property (p_trip) else $error("trip level not from level bit"); // see RL4

    property p_lp;
        ##1 cfg_q.lp_bor_on != $past(sup_cap[swc_pkg::SUP_LPBOR]);
    endproperty
    a_lp: assert property (p_lp) else $error("low-power brown-out polarity wrong"); // see RL5

    property p_delay;
        s_capture |=> dly_cnt == $past(dly_target);
    endproperty
    a_delay: assert property (p_delay) else $error("power-up delay count wrong"); // see RL6

    property p_pin;
        (state == swc_pkg::ST_RUN) && cfg_q.pin_is_reset && !pin_s2 |=> s_capture ##1 device_reset_hold;
    endproperty
    a_pin: assert property (p_pin) else $error("pin reset not taken"); // see RL8

    property p_wdog_on;
        presetn && (wdg_m == swc_pkg::MODE_ON) |=> cfg_q.wdog_running;
    endproperty
    a_wdog_on: assert property (p_wdog_on) else $error("watchdog not forced on"); // see RL13

    property p_wdog_off;
        wdg_m == swc_pkg::MODE_OFF |=> !cfg_q.wdog_running;
    endproperty
    a_wdog_off: assert property (p_wdog_off) else $error("watchdog runs while off"); // see RL15

    property p_period_load;
        s_capture and (cps == swc_pkg::CPS_SW) |=> per_run == swc_pkg::CPS_SW_LOAD;
    endproperty
    a_period_load: assert property (p_period_load) else $error("default period not loaded"); // see RL17

    property p_period_lock;
        (state == swc_pkg::ST_RUN) && !cfg_q.period_sw_ok |=> $stable(per_run);
    endproperty
    a_period_lock: assert property (p_period_lock) else $error("locked period changed"); // see RL17

    property p_win_lock;
        (state == swc_pkg::ST_RUN) && cfg_q.keyed_access |=> $stable(win_run);
    endproperty
    a_win_lock: assert property (p_win_lock) else $error("locked window changed"); // see RL12

    property p_hold;
        s_settled |-> $stable(sup_cap) && $stable(wdg_cap) && $stable(lvp_cap);
    endproperty
    a_hold: assert property (p_hold) else $error("captured settings moved"); // see RL19

endmodule // swc_top

`default_nettype wire

// >>> rtl/swc_pkg.sv
/*
 * Shared constants and carrier types for the supervisor and watchdog
 * configuration block: register indices, field positions, reset values,
 * mode codes, power-up delay times and the decoded settings struct.
 * Assumes a 10 MHz register clock.
 */
package swc_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam logic [15:0] IDX_SUP = 16'h8008;
    localparam logic [15:0] IDX_WDG = 16'h8009;
    localparam logic [15:0] IDX_CTRL = 16'h0000;
    localparam logic [15:0] IDX_RUN = 16'h0001;
    localparam logic [15:0] IDX_STAT = 16'h0002;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SUP_BROWNOUT_LEVEL_SELECT = 9;
    localparam int SUP_BROWNOUT_MODE_FIELD_LO = 6;
    localparam int SUP_LPBOR = 5;
    localparam int SUP_POWERUP_DELAY_SELECT_LO = 1;
    localparam int SUP_RESET_PIN_ENABLE = 0;
    localparam int WDG_CCS_LO = 11;
    localparam int WDG_CWS_LO = 8;
    localparam int WDG_MODE_LO = 5;
    localparam int WDG_CPS_LO = 0;
    localparam int CTRL_SBOR = 0;
    localparam int CTRL_SWDT = 1;
    localparam int CTRL_LVP = 2;
    localparam int CTRL_RESAMPLE = 3;
    localparam int CTRL_CLK_LO = 4;
    localparam int RUN_PER_LO = 0;
    localparam int RUN_WIN_LO = 8;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [13:0] CFG_RESET = 14'h3fff;
    localparam logic [5:0] CTRL_RESET = 6'h04;

    // ----------------------------------------------------------------
    // mode and code values
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_ON = 2'h3;
    localparam logic [1:0] MODE_AWAKE = 2'h2;
    localparam logic [1:0] MODE_SW = 2'h1;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [2:0] CCS_SW = 3'h7;
    localparam logic [2:0] CCS_LAST = 3'h2;
    localparam logic [1:0] CLK_NONE = 2'h3;
    localparam logic [2:0] CWS_FULL = 3'h6;
    localparam logic [2:0] CWS_CLOSED_BASE = 3'h7;
    localparam logic [4:0] CPS_SW = 5'h1f;
    localparam logic [4:0] CPS_SW_LOAD = 5'h0b;
    localparam logic [4:0] CPS_MAX = 5'h12;
    localparam logic [4:0] LOG2_MIN = 5'h05;

    // ----------------------------------------------------------------
    // power-up delay times
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned POWERUP_DELAY_TIMER_1_MS = 1;
    localparam int unsigned POWERUP_DELAY_TIMER_16_MS = 16;
    localparam int unsigned POWERUP_DELAY_TIMER_64_MS = 64;
    localparam int unsigned POWERUP_DELAY_TIMER_1MS_CYC = (POWERUP_DELAY_TIMER_1_MS * CLK_HZ + 999) / 1000;
    localparam int unsigned POWERUP_DELAY_TIMER_16MS_CYC = (POWERUP_DELAY_TIMER_16_MS * CLK_HZ + 999) / 1000;
    localparam int unsigned POWERUP_DELAY_TIMER_64MS_CYC = (POWERUP_DELAY_TIMER_64_MS * CLK_HZ + 999) / 1000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_CAPTURE, ST_DELAY, ST_RUN} swc_state_e;
    // order follows the two-bit delay field, 00 first
    typedef enum logic [1:0] {DLY_1MS, DLY_16MS, DLY_64MS, DLY_NONE} swc_delay_e;

    typedef struct packed {
        logic bor_active;
        logic bor_low_trip;
        logic lp_bor_on;
        swc_delay_e delay_sel;
        logic pin_is_reset;
        logic wdog_running;
        logic [1:0] wdog_clk;
        logic [2:0] win_closed;
        logic win_sw_ok;
        logic keyed_access;
        logic [4:0] period_log2;
        logic period_sw_ok;
    } swc_cfg_s;

endpackage

// >>> rtl/swc_decode.sv
/*
 * Combinational decode of the captured configuration words and the
 * live software bits into the supervisor and watchdog settings.
 * Assumes its word inputs are held stable by the capture logic around it.
 */
`timescale 1ns/1ps
`default_nettype none

module swc_decode (
    input wire logic [13:0] sup_word,
    input wire logic [13:0] wdg_word,
    input wire logic [4:0] period,
    input wire logic [2:0] window,
    input wire logic lvp_on,
    input wire logic sleep_active,
    input wire logic sw_bor_on,
    input wire logic sw_wdog_on,
    input wire logic [1:0] sw_clk_sel,
    output swc_pkg::swc_cfg_s cfg
);

    // ----------------------------------------------------------------
    // field extraction
    // ----------------------------------------------------------------
    wire logic [1:0] bor_mode = sup_word[swc_pkg::SUP_BROWNOUT_MODE_FIELD_LO +: 2];
    wire logic [1:0] wdg_mode = wdg_word[swc_pkg::WDG_MODE_LO +: 2];
    wire logic [2:0] clk_src = wdg_word[swc_pkg::WDG_CCS_LO +: 3];
    wire logic [2:0] win_cfg = wdg_word[swc_pkg::WDG_CWS_LO +: 3];
    wire logic [4:0] per_cfg = wdg_word[swc_pkg::WDG_CPS_LO +: 5];

    // shared on/awake/software/off decode
    wire logic bor_on = (bor_mode == swc_pkg::MODE_ON)
        | ((bor_mode == swc_pkg::MODE_AWAKE) & ~sleep_active)
        | ((bor_mode == swc_pkg::MODE_SW) & sw_bor_on);
    wire logic wdg_on = (wdg_mode == swc_pkg::MODE_ON)
        | ((wdg_mode == swc_pkg::MODE_AWAKE) & ~sleep_active)
        | ((wdg_mode == swc_pkg::MODE_SW) & sw_wdog_on);

    // reserved source codes give no clock
    wire logic [1:0] clk_sel = (clk_src == swc_pkg::CCS_SW) ? sw_clk_sel
        : (clk_src <= swc_pkg::CCS_LAST) ? clk_src[1:0] : swc_pkg::CLK_NONE;

    wire logic win_full = (window >= swc_pkg::CWS_FULL);
    wire logic [2:0] closed = win_full ? 3'h0 : 3'(swc_pkg::CWS_CLOSED_BASE - window);
    wire logic [4:0] log2 = (period <= swc_pkg::CPS_MAX) ? 5'(period + swc_pkg::LOG2_MIN)
        : swc_pkg::LOG2_MIN;

    // ----------------------------------------------------------------
    // settings out
    // ----------------------------------------------------------------
    assign cfg.bor_active = bor_on; // see RL1 see RL2 see RL3
    assign cfg.bor_low_trip = sup_word[swc_pkg::SUP_BROWNOUT_LEVEL_SELECT]; // see RL4 see RL18
    assign cfg.lp_bor_on = ~sup_word[swc_pkg::SUP_LPBOR]; // see RL5
    assign cfg.delay_sel = swc_pkg::swc_delay_e'(sup_word[swc_pkg::SUP_POWERUP_DELAY_SELECT_LO +: 2]); // see RL6
    assign cfg.pin_is_reset = lvp_on | sup_word[swc_pkg::SUP_RESET_PIN_ENABLE]; // see RL7 see RL8
    assign cfg.wdog_running = wdg_on; // see RL13 see RL14 see RL15
    assign cfg.wdog_clk = clk_sel; // see RL10
    assign cfg.win_closed = closed; // see RL12
    assign cfg.win_sw_ok = (win_cfg >= swc_pkg::CWS_FULL); // see RL11
    assign cfg.keyed_access = (win_cfg < swc_pkg::CWS_FULL); // see RL12
    assign cfg.period_log2 = log2; // see RL16
    assign cfg.period_sw_ok = (per_cfg == swc_pkg::CPS_SW); // see RL17

endmodule // swc_decode

`default_nettype wire

// >>> test/tb.sv
/*
 * Self-checking bench for the supervisor and watchdog configuration block:
 * programs the two configuration words over APB, restarts capture and
 * compares the decoded settings. Assumes assertions live in the design.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    // ------------------------------------------------------------
    // signals and design instance
    // ------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sleep_active = 1'b0;
    logic external_reset_pin = 1'b1;
    logic device_reset_hold;
    logic port_e_bit_three_sel;
    swc_pkg::swc_cfg_s cfg_out;
    logic [31:0] rdata;
    logic rerr;
    int failures = 0;
    int tests_run = 0;
    localparam logic [17:0] A_SUP = 18'h20020;
    localparam logic [17:0] A_WDG = 18'h20024;
    localparam logic [17:0] A_CTRL = 18'h00000;
    localparam logic [17:0] A_RUN = 18'h00004;

    swc_top #(.DLY_1MS_CYC(3), .DLY_16MS_CYC(5), .DLY_64MS_CYC(7)) swc_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_active(sleep_active), .external_reset_pin(external_reset_pin),
        .device_reset_hold(device_reset_hold), .port_e_bit_three_sel(port_e_bit_three_sel),
        .cfg_out(cfg_out)
    );

    // 10 MHz clock
    always #50 pclk = ~pclk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one APB transfer, setup then access until pready
    task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            chk(0, 1, "pready timeout");
            results();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [17:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp, "read data");
        chk(rerr, 0, "read error");
    endtask

    // wait for the hold to drop, bounded
    task automatic settle();
        int k;
        k = 0;
        while (device_reset_hold !== 1'b0 && k < 60) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 60) begin
            chk(0, 1, "hold timeout");
            results();
        end
        repeat (2) @(posedge pclk);
    endtask

    // program both words, then restart capture through the strobe
    task automatic capture(input logic [13:0] sup, input logic [13:0] wdg, input logic [5:0] ctrl);
        int k;
        apb(1'b1, A_SUP, {18'h0, sup | 14'h2000});
        apb(1'b1, A_WDG, {18'h0, wdg});
        apb(1'b1, A_CTRL, {26'h0, ctrl | 6'h08});
        k = 0;
        while (device_reset_hold !== 1'b1 && k < 8) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 8) begin
            chk(0, 1, "capture timeout");
            results();
        end
        settle();
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic eb;
        logic ep;
        logic [4:0] el;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        settle();
        rd(A_SUP, 32'h3fff);
        rd(A_WDG, 32'h3fff);
        rd(A_CTRL, 32'h04);
        apb(1'b0, 18'h00100, 32'h0);
        chk(rerr, 1, "unmapped");
        chk(cfg_out.bor_active, 1, "bor on");
        chk(cfg_out.bor_low_trip, 1, "low trip");
        chk(cfg_out.delay_sel, 3, "no delay");
        chk(cfg_out.period_log2, 16, "sw period");
        // modes, level, low-power, delay and clock codes 0..3
        for (int m = 0; m < 4; m++) begin
            capture({4'h0, m[0], 1'b0, m[1:0], ~m[1], 2'b00, m[1:0], 1'b1},
                    {m[2:0], m[2:0], 1'b0, m[1:0], m[4:0]}, 6'h04);
            chk(cfg_out.delay_sel, m, "delay");
            chk(cfg_out.lp_bor_on, m[1], "low power");
            chk(cfg_out.wdog_clk, m, "clock");
            chk(cfg_out.win_closed, 7 - m, "closed");
            chk({cfg_out.win_sw_ok, cfg_out.keyed_access}, 1, "keyed");
            for (int s = 0; s < 4; s++) begin
                apb(1'b1, A_CTRL, {28'h0, 2'b01, s[0], s[0]});
                sleep_active <= s[1];
                repeat (2) @(posedge pclk);
                eb = (m == 3) || (m == 2 && !s[1]) || (m == 1 && s[0]);
                chk(cfg_out.bor_active, eb, "bor mode");
                chk(cfg_out.wdog_running, eb, "wdog mode");
                if (eb) chk(cfg_out.bor_low_trip, m[0], "level");
            end
        end
        sleep_active <= 1'b0;
        // upper window and clock codes, reset pin function
        for (int w = 4; w < 8; w++) begin
            capture({13'h00c6, w[0]}, {w[2:0], w[2:0], 8'h13}, {w[1:0] - 2'd1, 1'b0, w[1], 2'b00});
            ep = w[1] | w[0];
            chk(cfg_out.wdog_clk, (w == 7) ? 2 : 3, "clock");
            chk(cfg_out.win_closed, (w > 5) ? 0 : 7 - w, "closed");
            chk(cfg_out.win_sw_ok, w > 5, "win sw");
            chk(cfg_out.keyed_access, w < 6, "keyed");
            chk(cfg_out.pin_is_reset, ep, "pin reset");
            chk(port_e_bit_three_sel, !ep, "port fn");
            apb(1'b1, A_RUN, 32'h0313);
            repeat (2) @(posedge pclk);
            chk(cfg_out.win_closed, (w > 5) ? 4 : 7 - w, "win lock");
            external_reset_pin <= 1'b0;
            repeat (6) @(posedge pclk);
            chk(device_reset_hold, ep, "pin hold");
            external_reset_pin <= 1'b1;
            settle();
        end
        // every default period code, then a runtime period write
        for (int c = 0; c < 32; c++) begin
            capture(14'h3fff, {9'h1ff, c[4:0]}, 6'h04);
            el = (c <= 18) ? 5'(c + 5) : ((c == 31) ? 5'd16 : 5'd5);
            chk(cfg_out.period_log2, el, "period");
            chk(cfg_out.period_sw_ok, c == 31, "lock");
            apb(1'b1, A_RUN, 32'h0702);
            repeat (2) @(posedge pclk);
            chk(cfg_out.period_log2, (c == 31) ? 7 : el, "sw period");
        end
        // a new word waits for the next capture
        apb(1'b1, A_SUP, 32'h2000);
        repeat (2) @(posedge pclk);
        chk(cfg_out.bor_active, 1, "held");
        rd(A_SUP, 32'h2000);
        results();
    end
endmodule // tb

`default_nettype wire
